// [hdl/vpd_page_responder.sv]
// What this block does
// - page 81h reports current, power-on default and up to four implemented definitions.
// - byte 4 holds current definition code in low seven bits, top bit zero.
// - default and listed definition bytes carry a top-bit save capable flag.
// - byte 5 reports the definition adopted at power application.
// - from byte 6 list at least one implemented definition with its flag.
// - byte 3 holds bytes following it, untruncated by allocation length.
// - supported pages list carries 00h in byte 1.
// - supported list from byte 4 is ascending, starting with 00h.
// - serial page carries 80h in byte 1, length equals serial byte count.
// - least significant serial character is the last byte of a full page.
// - without a serial number every serial byte is space 20h.
module vpd_page_responder (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic [31:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [31:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic req_valid_in,
  input wire vpd_pkg::vpd_req_s req_in,
  output logic req_ready_out,
  output logic req_err_out,
  output logic byte_valid_out,
  output vpd_pkg::vpd_byte_s byte_out,
  input wire logic byte_ready_in
);
  import vpd_pkg::*;

  vpd_state_s s_r;
  vpd_state_s s_nxt;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic req_fire;
  logic byte_fire;
  logic is_last;

  // number of implemented definitions, clamped to one..four
  function automatic logic [2:0] num_defs(input logic [31:0] ctrl);
    logic [2:0] nd;
    nd = ctrl[VPD_NDEF_LSB +: 3];
    if (nd == 3'h0)
      nd = 3'h1;
    else if (nd > VPD_MAX_DEFS)
      nd = VPD_MAX_DEFS;
    return nd;
  endfunction : num_defs

  function automatic logic supported(input logic [7:0] pg);
    return (pg == VPD_PG_LIST) || (pg == VPD_PG_SER) || (pg == VPD_PG_DEF);
  endfunction : supported

  // page length field: bytes following byte 3, never truncated
  function automatic logic [7:0] page_len(input logic [7:0] pg,
                                          input logic [31:0] ctrl);
    logic [7:0] len;
    len = 8'h00;
    unique case (pg)
      VPD_PG_LIST: len = VPD_LIST_LEN;
      VPD_PG_SER: len = VPD_SER_LEN;
      VPD_PG_DEF: len = VPD_DEF_FIXED + {5'h00, num_defs(ctrl)};
      default: len = 8'h00;
    endcase
    return len;
  endfunction : page_len

  // byte image of a page at a given index
  function automatic logic [7:0] page_byte(input vpd_state_s st,
                                           input logic [7:0] pg,
                                           input logic [7:0] idx);
    logic [7:0] b;
    logic [7:0] k;
    logic [7:0] sidx;
    b = 8'h00;
    k = idx - VPD_DEF_FIRST;
    sidx = idx - VPD_HDR_LEN;
    if (idx == 8'h00)
      b = st.ctrl[VPD_PERIPH_LSB +: 8];
    else if (idx == 8'h01)
      b = pg;
    else if (idx == 8'h02)
      b = 8'h00;
    else if (idx == 8'h03)
      b = page_len(pg, st.ctrl);
    else if (pg == VPD_PG_DEF)
    begin
      if (idx == 8'h04)
        b = {1'b0, st.ctrl[VPD_CUR_LSB +: 7]};
      else if (idx == 8'h05)
        b = {st.ctrl[VPD_DEF_SAVE_BIT], st.ctrl[VPD_DEF_LSB +: 7]};
      else if (k < {5'h00, num_defs(st.ctrl)})
        b = st.defs[k[1:0]*8 +: 8];
    end
    else if (pg == VPD_PG_LIST)
    begin
      if (idx == 8'h04)
        b = VPD_PG_LIST;
      else if (idx == 8'h05)
        b = VPD_PG_SER;
      else if (idx == 8'h06)
        b = VPD_PG_DEF;
    end
    else if (sidx < VPD_SER_LEN)
    begin
      if (st.ctrl[VPD_SER_AVAIL_BIT])
        b = st.ser[8'h3f - {sidx[2:0], 3'h0} -: 8];
      else
        b = VPD_SPACE;
    end
    return b;
  endfunction : page_byte

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = val[i*8 +: 8];
    return r;
  endfunction : merge

  assign s_axi_awready_out = ce_in && !s_r.aw_have && !s_r.bvalid;
  assign s_axi_wready_out = ce_in && !s_r.w_have && !s_r.bvalid;
  assign s_axi_arready_out = ce_in && !s_r.rvalid;
  assign s_axi_bvalid_out = s_r.bvalid;
  assign s_axi_bresp_out = s_r.bresp;
  assign s_axi_rvalid_out = s_r.rvalid;
  assign s_axi_rdata_out = s_r.rdata;
  assign s_axi_rresp_out = s_r.rresp;
  assign req_ready_out = ce_in && (s_r.fsm == VPD_IDLE);
  assign req_err_out = s_r.err;
  assign byte_valid_out = (s_r.fsm == VPD_SEND);
  assign is_last = (s_r.idx + 8'h01) == s_r.limit;
  assign byte_out = '{data: s_r.data, last: byte_valid_out && is_last};

  assign aw_fire = s_axi_awvalid_in && s_axi_awready_out;
  assign w_fire = s_axi_wvalid_in && s_axi_wready_out;
  assign ar_fire = s_axi_arvalid_in && s_axi_arready_out;
  assign req_fire = req_valid_in && req_ready_out;
  assign byte_fire = ce_in && byte_valid_out && byte_ready_in;

  always_comb
  begin
    logic [7:0] tot;
    tot = page_len(req_in.page, s_r.ctrl) + VPD_HDR_LEN;
    s_nxt = s_r;
    if (ce_in)
    begin
      if (s_r.bvalid && s_axi_bready_in)
        s_nxt.bvalid = 1'b0;
      if (s_r.rvalid && s_axi_rready_in)
        s_nxt.rvalid = 1'b0;
      if (aw_fire)
      begin
        s_nxt.aw_have = 1'b1;
        s_nxt.aw_addr = s_axi_awaddr_in;
      end
      if (w_fire)
      begin
        s_nxt.w_have = 1'b1;
        s_nxt.w_data = s_axi_wdata_in;
        s_nxt.w_strb = s_axi_wstrb_in;
      end
      if (s_nxt.aw_have && s_nxt.w_have)
      begin
        s_nxt.aw_have = 1'b0;
        s_nxt.w_have = 1'b0;
        s_nxt.bvalid = 1'b1;
        s_nxt.bresp = VPD_RESP_OKAY;
        unique case (s_nxt.aw_addr)
          VPD_OFS_CTRL:
            s_nxt.ctrl = merge(s_r.ctrl, s_nxt.w_data, s_nxt.w_strb);
          VPD_OFS_DEFS:
            s_nxt.defs = merge(s_r.defs, s_nxt.w_data, s_nxt.w_strb);
          VPD_OFS_SER_HI:
            s_nxt.ser[63:32] = merge(s_r.ser[63:32], s_nxt.w_data,
                                     s_nxt.w_strb);
          VPD_OFS_SER_LO:
            s_nxt.ser[31:0] = merge(s_r.ser[31:0], s_nxt.w_data,
                                    s_nxt.w_strb);
          VPD_OFS_STAT:
            if (s_nxt.w_strb[0] && s_nxt.w_data[VPD_ERR_BIT])
              s_nxt.err = 1'b0;
          default: s_nxt.bresp = VPD_RESP_SLVERR;
        endcase
      end
      if (ar_fire)
      begin
        s_nxt.rvalid = 1'b1;
        s_nxt.rresp = VPD_RESP_OKAY;
        s_nxt.rdata = 32'h0000_0000;
        unique case (s_axi_araddr_in)
          VPD_OFS_CTRL: s_nxt.rdata = s_r.ctrl;
          VPD_OFS_DEFS: s_nxt.rdata = s_r.defs;
          VPD_OFS_SER_HI: s_nxt.rdata = s_r.ser[63:32];
          VPD_OFS_SER_LO: s_nxt.rdata = s_r.ser[31:0];
          VPD_OFS_STAT:
          begin
            s_nxt.rdata[VPD_BUSY_BIT] = (s_r.fsm == VPD_SEND);
            s_nxt.rdata[VPD_ERR_BIT] = s_r.err;
            s_nxt.rdata[VPD_LAST_PG_LSB +: 8] = s_r.page;
            s_nxt.rdata[VPD_SENT_LSB +: 8] = s_r.sent;
          end
          default: s_nxt.rresp = VPD_RESP_SLVERR;
        endcase
      end
      // request handling after the clear so a new error wins
      if (req_fire)
      begin
        if (!supported(req_in.page))
          s_nxt.err = 1'b1;
        else
        begin
          s_nxt.page = req_in.page;
          s_nxt.sent = 8'h00;
          s_nxt.idx = 8'h00;
          s_nxt.limit = (req_in.alloc < tot) ? req_in.alloc : tot;
          s_nxt.data = page_byte(s_r, req_in.page, 8'h00);
          if (req_in.alloc != 8'h00)
            s_nxt.fsm = VPD_SEND;
        end
      end
      if (byte_fire)
      begin
        s_nxt.sent = s_r.sent + 8'h01;
        if (is_last)
          s_nxt.fsm = VPD_IDLE;
        else
        begin
          s_nxt.idx = s_r.idx + 8'h01;
          s_nxt.data = page_byte(s_r, s_r.page, s_r.idx + 8'h01);
        end
      end
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
    begin
      s_r <= '0;
      s_r.fsm <= VPD_IDLE;
      s_r.ctrl <= VPD_CTRL_RST;
      s_r.defs <= VPD_DEFS_RST;
      s_r.ser <= VPD_SER_RST;
    end
    else
      s_r <= s_nxt;
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  property p_def_current;
    byte_valid_out && s_r.page == VPD_PG_DEF && s_r.idx == 8'h04
      |-> byte_out.data == {1'b0, s_r.ctrl[6:0]};
  endproperty
  a_def_current: assert property (p_def_current)
    else $error("current definition byte wrong");

  property p_def_default;
    byte_valid_out && s_r.page == VPD_PG_DEF && s_r.idx == 8'h05
      |-> byte_out.data == {s_r.ctrl[15], s_r.ctrl[14:8]};
  endproperty
  a_def_default: assert property (p_def_default)
    else $error("default definition byte wrong");

  property p_def_list;
    byte_valid_out && s_r.page == VPD_PG_DEF && s_r.idx == 8'h06
      |-> byte_out.data == s_r.defs[7:0];
  endproperty
  a_def_list: assert property (p_def_list)
    else $error("first listed definition wrong");

  property p_def_code;
    req_fire && req_in.page == VPD_PG_DEF && req_in.alloc > 8'h01
      ##1 byte_fire [*2] |-> byte_out.data == 8'h81;
  endproperty
  a_def_code: assert property (p_def_code)
    else $error("definition page code wrong");

  property p_length;
    byte_valid_out && s_r.idx == 8'h03 |-> byte_out.data
      == (s_r.page == VPD_PG_LIST ? 8'h03 : s_r.page == VPD_PG_SER ? 8'h08
          : 8'h02 + {5'h00, num_defs(s_r.ctrl)});
  endproperty
  a_length: assert property (p_length)
    else $error("page length byte wrong");

  property p_list_code;
    byte_valid_out && s_r.page == VPD_PG_LIST && s_r.idx == 8'h01
      |-> byte_out.data == 8'h00;
  endproperty
  a_list_code: assert property (p_list_code)
    else $error("list page code wrong");

  property p_list_order;
    byte_valid_out && s_r.page == VPD_PG_LIST && s_r.idx >= 8'h04
      |-> byte_out.data == (s_r.idx == 8'h04 ? 8'h00
                            : s_r.idx == 8'h05 ? 8'h80 : 8'h81);
  endproperty
  a_list_order: assert property (p_list_order)
    else $error("supported list not ascending");

  property p_ser_code;
    byte_valid_out && s_r.page == VPD_PG_SER && s_r.idx == 8'h01
      |-> byte_out.data == 8'h80 && s_r.limit <= 8'h0c;
  endproperty
  a_ser_code: assert property (p_ser_code)
    else $error("serial page code or length wrong");

  property p_ser_last;
    byte_valid_out && byte_out.last && s_r.page == VPD_PG_SER
      && s_r.idx == 8'h0b && s_r.ctrl[31]
      |-> byte_out.data == s_r.ser[7:0];
  endproperty
  a_ser_last: assert property (p_ser_last)
    else $error("serial last byte not least significant");

  property p_ser_space;
    byte_valid_out && s_r.page == VPD_PG_SER && s_r.idx >= 8'h04
      && !s_r.ctrl[31] |-> byte_out.data == 8'h20;
  endproperty
  a_ser_space: assert property (p_ser_space)
    else $error("missing serial not space filled");

  property p_reserved;
    byte_valid_out && s_r.idx == 8'h02 |-> byte_out.data == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved byte not zero");

  property p_stop;
    byte_fire && byte_out.last |=> !byte_valid_out && s_r.sent <= s_r.limit;
  endproperty
  a_stop: assert property (p_stop)
    else $error("transfer did not stop at limit");

  c_def_page: cover property (byte_fire && byte_out.last
                              && s_r.page == VPD_PG_DEF);
  c_truncated: cover property (byte_fire && byte_out.last
                               && s_r.limit < page_len(s_r.page, s_r.ctrl)
                                  + VPD_HDR_LEN);
  c_no_serial: cover property (byte_fire && byte_out.last
                               && s_r.page == VPD_PG_SER && !s_r.ctrl[31]);
  c_axi_write: cover property (s_axi_bvalid_out && s_axi_bready_in);
endmodule : vpd_page_responder

// [hdl/vpd_pkg.sv]
package vpd_pkg;
  // register byte addresses
  localparam logic [31:0] VPD_OFS_CTRL = 32'h0000_0000;
  localparam logic [31:0] VPD_OFS_DEFS = 32'h0000_0004;
  localparam logic [31:0] VPD_OFS_SER_HI = 32'h0000_0008;
  localparam logic [31:0] VPD_OFS_SER_LO = 32'h0000_000c;
  localparam logic [31:0] VPD_OFS_STAT = 32'h0000_0010;
  // control register fields
  localparam int VPD_CUR_LSB = 0;
  localparam int VPD_DEF_LSB = 8;
  localparam int VPD_DEF_SAVE_BIT = 15;
  localparam int VPD_PERIPH_LSB = 16;
  localparam int VPD_NDEF_LSB = 24;
  localparam int VPD_SER_AVAIL_BIT = 31;
  // status register fields
  localparam int VPD_BUSY_BIT = 0;
  localparam int VPD_ERR_BIT = 1;
  localparam int VPD_LAST_PG_LSB = 8;
  localparam int VPD_SENT_LSB = 16;
  // reset values
  localparam logic [31:0] VPD_CTRL_RST = 32'h0100_0000;
  localparam logic [31:0] VPD_DEFS_RST = 32'h0000_0000;
  localparam logic [31:0] VPD_SER_RST = 32'h0000_0000;
  // page codes and page layout
  localparam logic [7:0] VPD_PG_LIST = 8'h00;
  localparam logic [7:0] VPD_PG_SER = 8'h80;
  localparam logic [7:0] VPD_PG_DEF = 8'h81;
  localparam logic [7:0] VPD_SPACE = 8'h20;
  localparam logic [7:0] VPD_HDR_LEN = 8'h04;
  localparam logic [7:0] VPD_LIST_LEN = 8'h03;
  localparam logic [7:0] VPD_SER_LEN = 8'h08;
  localparam logic [7:0] VPD_DEF_FIXED = 8'h02;
  localparam logic [7:0] VPD_DEF_FIRST = 8'h06;
  localparam logic [2:0] VPD_MAX_DEFS = 3'h4;
  // axi responses
  localparam logic [1:0] VPD_RESP_OKAY = 2'h0;
  localparam logic [1:0] VPD_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    VPD_IDLE = 2'b01,
    VPD_SEND = 2'b10
  } vpd_fsm_e;

  typedef struct packed {
    logic [7:0] page;
    logic [7:0] alloc;
  } vpd_req_s;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } vpd_byte_s;

  typedef struct packed {
    vpd_fsm_e fsm;
    logic [31:0] ctrl;
    logic [31:0] defs;
    logic [63:0] ser;
    logic err;
    logic [7:0] page;
    logic [7:0] limit;
    logic [7:0] idx;
    logic [7:0] data;
    logic [7:0] sent;
    logic aw_have;
    logic [31:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } vpd_state_s;
endpackage : vpd_pkg

// [test/vpd_initiator.sv]
module vpd_initiator (
  input wire logic clock_in,
  input wire logic req_ready_in,
  input wire logic byte_valid_in,
  input wire vpd_pkg::vpd_byte_s byte_in,
  output logic req_valid_out,
  output vpd_pkg::vpd_req_s req_out,
  output logic byte_ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import vpd_pkg::*;
  logic [7:0] got [256];
  int n = 0;
  int last_at = -1;

  initial
  begin
    req_valid_out = 1'b0;
    req_out = '0;
    byte_ready_out = 1'b0;
  end

  // request a page, then take bytes, every other cycle when slow
  task automatic fetch(input logic [7:0] pg, input logic [7:0] al,
                       input bit slow);
    @(posedge clock_in);
    n = 0;
    last_at = -1;
    req_valid_out <= 1'b1;
    req_out <= '{page: pg, alloc: al};
    do @(negedge clock_in); while (!req_ready_in);
    @(posedge clock_in);
    req_valid_out <= 1'b0;
    // released request lines show the inverse, not the old value
    req_out <= ~req_out;
    byte_ready_out <= 1'b1;
    forever
    begin
      @(negedge clock_in);
      if (!byte_valid_in)
        break;
      if (byte_ready_out)
      begin
        got[n] = byte_in.data;
        if (byte_in.last)
          last_at = n;
        n++;
      end
      @(posedge clock_in);
      byte_ready_out <= slow ? !byte_ready_out : 1'b1;
    end
    @(posedge clock_in);
    byte_ready_out <= 1'b0;
  endtask : fetch
endmodule : vpd_initiator

// [test/vpd_page_responder_tb.sv]
module vpd_page_responder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import vpd_pkg::*;
  typedef struct {
    logic [31:0] ctrl;
    logic [31:0] defs;
    logic [7:0] pg;
    logic [7:0] al;
    bit slow;
    logic [7:0] n;
  } vpd_row_s;
  // configuration and request beside the byte count it should give
  vpd_row_s rows [9] = '{
    '{32'h0100_0000, 32'h0, 8'h00, 8'hff, 1'b0, 8'h07},
    '{32'h0100_0000, 32'h0, 8'h80, 8'hff, 1'b1, 8'h0c},
    '{32'h8342_8d05, 32'h0403_8281, 8'h80, 8'hff, 1'b1, 8'h0c},
    '{32'h8342_8d05, 32'h0403_8281, 8'h81, 8'hff, 1'b0, 8'h09},
    '{32'h8342_8d05, 32'h0403_8281, 8'h81, 8'h02, 1'b0, 8'h02},
    '{32'h8342_8d05, 32'h0403_8281, 8'h80, 8'h04, 1'b1, 8'h04},
    '{32'h0700_0085, 32'hc403_8201, 8'h81, 8'hff, 1'b1, 8'h0a},
    '{32'h0000_0000, 32'h0000_0003, 8'h81, 8'h40, 1'b0, 8'h07},
    '{32'h0100_0000, 32'h0, 8'h00, 8'h00, 1'b0, 8'h00}
  };
  logic [31:0] offs [5] = '{VPD_OFS_CTRL, VPD_OFS_DEFS, VPD_OFS_SER_HI,
                            VPD_OFS_SER_LO, VPD_OFS_STAT};
  logic [31:0] rstv [5] = '{VPD_CTRL_RST, VPD_DEFS_RST, VPD_SER_RST,
                            VPD_SER_RST, 32'h0};
  logic clk, rstn, ce, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic req_valid, req_ready, req_err, byte_valid, byte_ready;
  logic [31:0] awaddr, wdata, araddr, rdata, ctrl, defs, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [7:0] g, e;
  vpd_req_s req;
  vpd_byte_s byt;
  logic [31:0] hi = 32'h534e_3132;
  logic [31:0] lo = 32'h3334_3536;
  int bad_count = 0;
  int checked = 0;

  vpd_page_responder vpd_page_responder_i (
    .clock_in(clk), .rstn_in(rstn), .ce_in(ce),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .req_valid_in(req_valid), .req_in(req),
    .req_ready_out(req_ready), .req_err_out(req_err),
    .byte_valid_out(byte_valid), .byte_out(byt),
    .byte_ready_in(byte_ready)
  );

  vpd_initiator vpd_initiator_i (
    .clock_in(clk), .req_ready_in(req_ready), .byte_valid_in(byte_valid),
    .byte_in(byt), .req_valid_out(req_valid), .req_out(req),
    .byte_ready_out(byte_ready)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] gv, input logic [31:0] ev);
    checked++;
    if (gv !== ev)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, gv, ev);
    end
  endtask : chk

  task automatic results();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task automatic wr(input logic [31:0] a, input logic [31:0] v,
                    output logic [1:0] r);
    bit ah = 0;
    bit wh = 0;
    bit ta, tw;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ah && wh))
    begin
      @(negedge clk);
      ta = !ah && awready;
      tw = !wh && wready;
      @(posedge clk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      ah = ah || ta;
      wh = wh || tw;
    end
    do @(negedge clk); while (!bvalid);
    r = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    v = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask : rd

  // expected page byte from the current configuration
  function automatic logic [7:0] expb(input logic [7:0] pg, input int i);
    int n;
    logic [63:0] s;
    n = (ctrl[26:24] == 3'h0) ? 1 : (ctrl[26:24] > 3'h4) ? 4 : ctrl[26:24];
    s = {hi, lo};
    if (i == 0)
      return ctrl[23:16];
    if (i == 1)
      return pg;
    if (i == 2)
      return 8'h00;
    if (pg == 8'h00)
      return (i == 3) ? 8'h03 : (i == 4) ? 8'h00 : (i == 5) ? 8'h80 : 8'h81;
    if (pg == 8'h80)
      return (i == 3) ? 8'h08 : ctrl[31] ? s[8*(11-i) +: 8] : 8'h20;
    if (i == 3)
      return 8'(2 + n);
    if (i == 4)
      return {1'b0, ctrl[6:0]};
    if (i == 5)
      return ctrl[15:8];
    return defs[8*(i-6) +: 8];
  endfunction : expb

  initial
  begin
    {rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'h0;
    ce = 1'b1;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    wr(VPD_OFS_SER_HI, hi, rs);
    wr(VPD_OFS_SER_LO, lo, rs);
    foreach (rows[r])
    begin
      ctrl = rows[r].ctrl;
      defs = rows[r].defs;
      wr(VPD_OFS_CTRL, ctrl, rs);
      wr(VPD_OFS_DEFS, defs, rs);
      vpd_initiator_i.fetch(rows[r].pg, rows[r].al, rows[r].slow);
      chk(vpd_initiator_i.n, {24'h0, rows[r].n});
      for (int i = 0; i < vpd_initiator_i.n; i++)
      begin
        g = vpd_initiator_i.got[i];
        e = expb(rows[r].pg, i);
        if (rows[r].pg == VPD_PG_DEF)
          chk({24'h0, g}, {24'h0, e});
        else if (rows[r].pg == VPD_PG_LIST)
          chk({24'h0, g}, {24'h0, e});
        else
          chk({24'h0, g}, {24'h0, e});
      end
      if (vpd_initiator_i.n > 0)
        chk(vpd_initiator_i.last_at, vpd_initiator_i.n - 1);
      rd(VPD_OFS_STAT, d, rs);
      chk(d, {8'h00, rows[r].n, rows[r].pg, 8'h00});
      $display("test %0d done", r);
    end
    vpd_initiator_i.fetch(8'h82, 8'hff, 1'b0);
    chk(vpd_initiator_i.n, 32'h0);
    chk({31'h0, req_err}, 32'h1);
    wr(VPD_OFS_STAT, 32'h2, rs);
    chk({31'h0, req_err}, 32'h0);
    $display("test unsupported page done");
    wr(32'h40, 32'h1, rs);
    chk({30'h0, rs}, {30'h0, VPD_RESP_SLVERR});
    rd(32'h40, d, rs);
    chk({30'h0, rs}, {30'h0, VPD_RESP_SLVERR});
    chk(d, 32'h0);
    $display("test unmapped done");
    ce <= 1'b0;
    @(negedge clk);
    chk({28'h0, awready, wready, arready, req_ready}, 32'h0);
    @(posedge clk);
    ce <= 1'b1;
    $display("test clock enable done");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    foreach (offs[k])
    begin
      rd(offs[k], d, rs);
      chk(d, rstv[k]);
    end
    $display("test reset done");
    results();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end
endmodule : vpd_page_responder_tb
